// ### design/hirp_port.sv
// host register port: index, indirect data window and compressed stream word
`timescale 1ns/1ps
`include "hirp_defines.svh"
module hirp_port #(
    parameter int FIFO_DEPTH = `HIRP_FIFO_DEPTH,
    parameter int HALT_MARGIN = `HIRP_HALT_MARGIN,
    parameter int SRQ_MARGIN = `HIRP_SRQ_MARGIN,
    parameter int IND_AW = `HIRP_IND_AW
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // host bus (already synchronous to clk)
    input wire hirp_pkg::hirp_req_t host_req,
    output logic [31:0] host_rdata,
    // mode
    input wire hirp_pkg::hirp_mode_t codec_mode,
    // coder side: encode fills, decode drains
    input wire logic coder_in_valid,
    output logic coder_in_ready,
    input wire logic [31:0] coder_in_data,
    output logic coder_out_valid,
    input wire logic coder_out_ready,
    output logic [31:0] coder_out_data,
    // indirect register write port
    output logic ind_wr,
    output logic [15:0] ind_addr,
    output logic [15:0] ind_wdata,
    // buffer status
    output logic buffer_halt_flag,
    output logic buffer_service_request,
    output logic buffer_error_flag
);
    localparam int LW = $clog2(FIFO_DEPTH + 1);
    logic [15:0] index_pointer_reg;
    logic [15:0] indirect_value_reg;
    logic [15:0] ind_mem_reg [2**IND_AW];
    logic [31:0] stream_word_reg;
    logic [31:0] rdata_reg;
    logic [15:0] window_next;
    logic [31:0] stream_next;
    logic [15:0] ind_read;
    logic sel_index;
    logic sel_window;
    logic sel_stream;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [31:0] fifo_in_data;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [31:0] fifo_out_data;
    logic [LW-1:0] level;
    logic word_done;
    logic encode;

    assign encode = (codec_mode == hirp_pkg::HIRP_ENCODE);
    assign sel_index = host_req.addr == `HIRP_OFS_INDEX;
    assign sel_window = host_req.addr == `HIRP_OFS_WINDOW;
    assign sel_stream = host_req.addr == `HIRP_OFS_STREAM;
    assign ind_read = ind_mem_reg[index_pointer_reg[IND_AW-1:0]];

    // byte-lane merge of the window and stream writes
    always_comb begin
        window_next = indirect_value_reg;
        stream_next = stream_word_reg;
        for (int i = 0; i < 2; i++) begin
            if (host_req.be[i]) begin
                window_next[i*8 +: 8] = host_req.wdata[i*8 +: 8];
            end
        end
        for (int i = 0; i < 4; i++) begin
            if (host_req.be[i]) begin
                stream_next[i*8 +: 8] = host_req.wdata[i*8 +: 8];
            end
        end
    end

    // index: upper 16 bits dropped on write
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            index_pointer_reg <= 16'h0000;
        end else if (host_req.wr && sel_index) begin
            if (host_req.be[0]) index_pointer_reg[7:0] <= host_req.wdata[7:0];
            if (host_req.be[1]) index_pointer_reg[15:8] <= host_req.wdata[15:8];
        end else if ((host_req.wr || host_req.rd) && sel_window && host_req.be[1]) begin
            // byte bus: low byte first so the upper lane closes the access
            index_pointer_reg <= index_pointer_reg + 16'h0001;
        end
    end

    // holding register for the window; write of the upper byte commits it
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            indirect_value_reg <= 16'h0000;
        end else if (host_req.wr && sel_window) begin
            indirect_value_reg <= window_next;
        end
    end

    assign ind_wr = host_req.wr && sel_window && host_req.be[1];
    assign ind_addr = index_pointer_reg;
    assign ind_wdata = window_next;

    // local shadow of the indirect space, only low IND_AW index bits decode
    always_ff @(posedge clk) begin
        if (ind_wr) begin
            ind_mem_reg[index_pointer_reg[IND_AW-1:0]] <= window_next;
        end
    end

    // stream word assembly; lanes ascend so lane 3 finishes the word
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stream_word_reg <= 32'h00000000;
        end else if (host_req.wr && sel_stream) begin
            stream_word_reg <= stream_next;
        end else if (host_req.rd && sel_stream && host_req.be[3] && fifo_out_valid) begin
            stream_word_reg <= fifo_out_data;
        end
    end

    assign word_done = sel_stream && host_req.be[3];

    // decode: host fills, coder drains; encode: coder fills, host drains
    assign fifo_in_valid = encode ? coder_in_valid : (host_req.wr && word_done);
    assign fifo_in_data = encode ? coder_in_data : stream_next;
    assign coder_in_ready = encode && fifo_in_ready;
    assign fifo_out_ready = encode ? (host_req.rd && word_done) : coder_out_ready;
    assign coder_out_valid = !encode && fifo_out_valid;
    assign coder_out_data = fifo_out_data;

    hirp_fifo #(
        .WIDTH(32),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data),
        .level(level)
    );

    // halt early in decode to leave write slack for a host burst
    always_comb begin
        if (encode) begin
            buffer_halt_flag = (level == '0);
            buffer_service_request = (level >= LW'(FIFO_DEPTH - SRQ_MARGIN));
        end else begin
            buffer_halt_flag = (level >= LW'(FIFO_DEPTH - HALT_MARGIN));
            buffer_service_request = (level <= LW'(SRQ_MARGIN));
        end
    end

    // sticky until reset; set on an overflow drop in either mode or on a coder empty read in decode
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            buffer_error_flag <= 1'b0;
        end else if (encode && coder_in_valid && !fifo_in_ready) begin
            buffer_error_flag <= 1'b1;
        end else if (!encode && coder_out_ready && !fifo_out_valid) begin
            buffer_error_flag <= 1'b1;
        end else if (!encode && host_req.wr && word_done && !fifo_in_ready) begin
            buffer_error_flag <= 1'b1;
        end
    end

    // read data one cycle after the strobe; reserved bits zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_reg <= 32'h00000000;
        end else if (host_req.rd) begin
            if (sel_window) begin
                rdata_reg <= {16'h0000, ind_read};
            end else if (sel_stream) begin
                rdata_reg <= fifo_out_data;
            end else begin
                rdata_reg <= 32'h00000000;
            end
        end
    end
    assign host_rdata = rdata_reg;
endmodule : hirp_port

// ### design/hirp_defines.svh
// offsets and counts for the host indirect register port
// Function
// - Write-only index register at offset 0x00; low 16 bits select the indirect register.
// - Every indirect register written through the data window is 16 bits wide.
// - Index increments by one after each completed data window access.
// - On a byte bus, increment happens only on the upper byte lane access.
// - Index and window reset undefined; bits 31:16 read zero, writes ignored.
// - Data window at 0x04 writes or reads the indexed 16-bit indirect register.
// - Stream register at 0x08 carries 32-bit compressed words, undefined at reset.
// - Stream register backed by a 512 by 32-bit FIFO.
// - In decode, halt flag asserts while 32 empty entries remain.
// - Service request near full/empty; error flag on overflow/underflow (code flags underflow only on coder reads in decode, not host reads in encode).
`ifndef HIRP_DEFINES_SVH
`define HIRP_DEFINES_SVH
`define HIRP_OFS_INDEX 4'h0
`define HIRP_OFS_WINDOW 4'h4
`define HIRP_OFS_STREAM 4'h8
`define HIRP_FIFO_DEPTH 512
`define HIRP_HALT_MARGIN 32
`define HIRP_SRQ_MARGIN 128
`define HIRP_IND_AW 8
`endif

// ### design/hirp_pkg.sv
// types shared by the host indirect register port
package hirp_pkg;
    typedef struct packed {
        logic [3:0] addr;
        logic [3:0] be;
        logic wr;
        logic rd;
        logic [31:0] wdata;
    } hirp_req_t;
    typedef enum logic {HIRP_DECODE, HIRP_ENCODE} hirp_mode_t;
endpackage : hirp_pkg

// ### design/hirp_fifo.sv
// synchronous flop fifo with valid/ready on both sides and fill level
`timescale 1ns/1ps
module hirp_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // occupancy
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wp_reg;
    logic [AW-1:0] rp_reg;
    logic [$clog2(DEPTH+1)-1:0] cnt_reg;
    logic push;
    logic pop;

    assign in_ready = (cnt_reg != DEPTH[$clog2(DEPTH+1)-1:0]);
    assign out_valid = (cnt_reg != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_reg[rp_reg];
    assign level = cnt_reg;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wp_reg] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wp_reg <= (wp_reg == AW'(DEPTH - 1)) ? '0 : wp_reg + 1'b1;
            end
            if (pop) begin
                rp_reg <= (rp_reg == AW'(DEPTH - 1)) ? '0 : rp_reg + 1'b1;
            end
            if (push && !pop) begin
                cnt_reg <= cnt_reg + 1'b1;
            end else if (pop && !push) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end
endmodule : hirp_fifo

// ### sim/hirp_port_props.sv
// concurrent checks on the host indirect register port
`timescale 1ns/1ps
module hirp_port_props (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // host bus and mode
    input wire hirp_pkg::hirp_req_t host_req,
    input wire logic [31:0] host_rdata,
    input wire hirp_pkg::hirp_mode_t codec_mode,
    // coder side
    input wire logic coder_in_valid,
    input wire logic coder_in_ready,
    input wire logic [31:0] coder_in_data,
    input wire logic coder_out_valid,
    input wire logic coder_out_ready,
    input wire logic [31:0] coder_out_data,
    // indirect port and status
    input wire logic ind_wr,
    input wire logic [15:0] ind_addr,
    input wire logic [15:0] ind_wdata,
    input wire logic buffer_halt_flag,
    input wire logic buffer_service_request,
    input wire logic buffer_error_flag
);
    logic win;
    logic sw;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    assign win = (host_req.wr | host_req.rd) && host_req.addr == 4'h4;
    // only decode writes are checked: encode pushes come from the coder
    assign sw = host_req.wr && host_req.addr == 4'h8 && codec_mode == hirp_pkg::HIRP_DECODE;
    property p_load; host_req.wr && host_req.addr == 4'h0 && host_req.be[1:0] == 2'h3
        |=> ind_addr == $past(host_req.wdata[15:0]); endproperty
    a_load: assert property (p_load) else $error("index not loaded");
    property p_inc; win && host_req.be[1] |=> ind_addr == $past(ind_addr) + 16'h1; endproperty
    a_inc: assert property (p_inc) else $error("index not advanced");
    property p_hold; win && !host_req.be[1] |=> $stable(ind_addr); endproperty
    a_hold: assert property (p_hold) else $error("index moved on low byte");
    property p_wdat; ind_wr |-> ind_wdata[15:8] == host_req.wdata[15:8]; endproperty
    a_wdat: assert property (p_wdat) else $error("window data wrong");
    property p_wstb; ind_wr |-> host_req.wr && host_req.addr == 4'h4 && host_req.be[1]; endproperty
    a_wstb: assert property (p_wstb) else $error("indirect write without upper lane");
    property p_wfull; ind_wr && host_req.be[0] |-> ind_wdata == host_req.wdata[15:0]; endproperty
    a_wfull: assert property (p_wfull) else $error("full window word wrong");
    property p_zero; host_req.rd && host_req.addr[3:2] != 2'h2 |=> host_rdata[31:16] == 16'h0; endproperty
    a_zero: assert property (p_zero) else $error("upper read bits set");
    property p_early; sw && !coder_out_valid && !host_req.be[3] |=> !coder_out_valid; endproperty
    a_early: assert property (p_early) else $error("buffer advanced early");
    property p_push; sw && !coder_out_valid && host_req.be[3] |=> coder_out_valid; endproperty
    a_push: assert property (p_push) else $error("buffer not advanced");
    property p_safe; sw && !buffer_halt_flag && !buffer_error_flag |=> !buffer_error_flag; endproperty
    a_safe: assert property (p_safe) else $error("overflow before halt");
    property p_stick; buffer_error_flag |=> buffer_error_flag; endproperty
    a_stick: assert property (p_stick) else $error("error flag dropped");
endmodule : hirp_port_props
bind hirp_port hirp_port_props u_props (.clk, .sys_rst, .host_req, .host_rdata, .codec_mode, .coder_in_valid,
    .coder_in_ready, .coder_in_data, .coder_out_valid, .coder_out_ready, .coder_out_data, .ind_wr, .ind_addr,
    .ind_wdata, .buffer_halt_flag, .buffer_service_request, .buffer_error_flag);

// ### sim/hirp_host.sv
// host processor model: one bus access per call
`timescale 1ns/1ps
module hirp_host (
    // bus
    input wire logic clk,
    output hirp_pkg::hirp_req_t req,
    input wire logic [31:0] rdata
);
    initial req = '0;
    task automatic acc(input logic w, input logic [3:0] a, b, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        #1 req = {a, b, w, !w, d};
        @(posedge clk);
        #1 req = {4'hF, 4'h0, 2'h0, ~d}; // released bus shows no stale data
        q = rdata;
    endtask : acc
endmodule : hirp_host

// ### sim/tb_top.sv
// self-checking bench for the host indirect register port
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic in_valid = 1'b0;
    logic out_ready = 1'b0;
    logic [31:0] cin = 32'h0;
    logic [31:0] q;
    logic [31:0] rdata;
    logic [31:0] out_data;
    logic out_valid;
    logic halt;
    logic srq;
    logic err;
    logic in_rdy;
    logic ind_wr;
    logic [15:0] ind_addr;
    logic [15:0] ind_wdata;
    hirp_pkg::hirp_req_t req;
    hirp_pkg::hirp_mode_t mode = hirp_pkg::HIRP_DECODE;
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    always #4 clk = ~clk;
    hirp_host host (.clk(clk), .req(req), .rdata(rdata));
    hirp_port #(.FIFO_DEPTH(64), .HALT_MARGIN(8), .SRQ_MARGIN(16), .IND_AW(8)) dut (.clk(clk), .sys_rst(sys_rst),
        .host_req(req), .host_rdata(rdata), .codec_mode(mode), .coder_in_valid(in_valid), .coder_in_ready(in_rdy),
        .coder_in_data(cin), .coder_out_valid(out_valid), .coder_out_ready(out_ready), .coder_out_data(out_data),
        .ind_wr(ind_wr), .ind_addr(ind_addr), .ind_wdata(ind_wdata), .buffer_halt_flag(halt),
        .buffer_service_request(srq),
        .buffer_error_flag(err));
    function automatic logic [31:0] w(input int i);
        return 32'hA500_0000 + 32'(i);
    endfunction : w
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [3:0] b, input logic [31:0] d);
        host.acc(1'b1, a, b, d, q);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [3:0] b);
        host.acc(1'b0, a, b, 32'h0, q);
    endtask : rd
    task automatic final_report();
        $display("errors %0d checks %0d", num_errors, total_checks);
        if (num_errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            num_errors++;
            final_report();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        #1 sys_rst = 1'b0;
        wr(4'h0, 4'hF, 32'hFFFF_0010);
        chk(32'(ind_addr), 32'h0000_0010);
        wr(4'h4, 4'h3, 32'hFFFF_1111);
        wr(4'h4, 4'h3, 32'h0000_2222);
        chk(32'(ind_addr), 32'h0000_0012);
        wr(4'h0, 4'hF, 32'h0000_0010);
        rd(4'h4, 4'h3);
        chk(q, 32'h0000_1111);
        rd(4'h4, 4'h3);
        chk(q, 32'h0000_2222);
        wr(4'h0, 4'hF, 32'h0000_0020);
        wr(4'h4, 4'h1, 32'h0000_0033); // low byte first
        chk(32'(ind_addr), 32'h0000_0020);
        chk(32'(ind_wdata), 32'h0000_2233);
        wr(4'h4, 4'h2, 32'h0000_4400);
        wr(4'h0, 4'hF, 32'h0000_0020);
        rd(4'h4, 4'h3);
        chk(q, 32'h0000_4433);
        rd(4'hC, 4'hF);
        chk(q, 32'h0);
        chk(32'(srq), 32'h1);
        for (int i = 0; i < 3; i++) wr(4'h8, 4'(4'h1 << i), w(0)); // ascending lanes
        chk(32'(out_valid), 32'h0);
        wr(4'h8, 4'h8, w(0));
        wr(4'h8, 4'h3, w(1)); // lower half first
        wr(4'h8, 4'hC, w(1));
        for (int i = 2; i < 55; i++) wr(4'h8, 4'hF, w(i));
        chk(32'(halt), 32'h0);
        wr(4'h8, 4'hF, w(55));
        chk(32'(halt), 32'h1);
        chk(32'(srq), 32'h0);
        for (int i = 56; i < 64; i++) wr(4'h8, 4'hF, w(i));
        chk(32'(err), 32'h0);
        wr(4'h8, 4'hF, w(99));
        chk(32'(err), 32'h1);
        out_ready = 1'b1;
        for (int i = 0; i < 64; i++) begin
            chk(out_data, w(i));
            @(posedge clk);
            #1;
        end
        out_ready = 1'b0;
        chk(32'(out_valid), 32'h0);
        chk(32'(srq), 32'h1);
        sys_rst = 1'b1;
        mode = hirp_pkg::HIRP_ENCODE;
        repeat (2) @(posedge clk);
        #1 sys_rst = 1'b0;
        chk(32'(err), 32'h0);
        chk(32'(halt), 32'h1);
        chk(32'(in_rdy), 32'h1);
        // one push past full: the last beat must be refused and flagged
        in_valid = 1'b1;
        for (int i = 0; i < 65; i++) begin
            cin = w(100 + i);
            @(posedge clk);
            #1;
        end
        in_valid = 1'b0;
        chk(32'(in_rdy), 32'h0);
        chk(32'(err), 32'h1);
        chk(32'(srq), 32'h1);
        chk(32'(halt), 32'h0);
        for (int i = 0; i < 3; i++) begin
            rd(4'h8, 4'hF);
            chk(q, w(100 + i));
        end
        final_report();
    end
endmodule : tb_top
